// File: hdl/msq_pkg.sv
// Purpose: constants and types for the step eight / step nine setup registers
// Assumes: 16-bit registers reached over a plain strobe port
// Notes: offsets are register addresses on the port
package msq_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam logic [7:0] STEP8_OFFSET = 8'h98;
   localparam logic [7:0] STEP9_OFFSET = 8'h99;
   localparam logic [15:0] STEP8_RESET = 16'h0008;
   localparam logic [15:0] STEP9_RESET = 16'h0009;
   localparam int unsigned ACTIVE_BIT = 15;
   localparam int unsigned GAIN_HI = 14;
   localparam int unsigned GAIN_LO = 13;
   localparam int unsigned NEG_BIT = 4;
   localparam int unsigned POS_HI = 3;
   localparam int unsigned POS_LO = 0;
   localparam logic [15:0] WRITABLE_MASK = 16'he01f;
   localparam logic [3:0] POS_INTERNAL_FIRST = 4'h8;

   typedef enum logic [1:0] {
      MSQ_GAIN_ONE,
      MSQ_GAIN_TWO,
      MSQ_GAIN_FOUR
   } msq_gain_e;

   typedef enum logic [1:0] {
      MSQ_NEG_GROUND,
      MSQ_NEG_EXT_SEVEN,
      MSQ_NEG_AUTO
   } msq_neg_e;

   // decoded view of one step's setup
   typedef struct packed {
      logic active;
      msq_gain_e gain;
      msq_neg_e neg_src;
      logic [3:0] pos_sel;
      logic pos_internal;
   } msq_step_s;
endpackage

// File: hdl/msq_step_reg.sv
// Purpose: one step setup register with reserved bits held at zero
// Assumes: single clock, async active-high reset
// Notes: decodes the fields for the sequencer
`timescale 1ns/10ps
`default_nettype none
module msq_step_reg #(
   parameter logic [15:0] RESET_VAL = msq_pkg::STEP8_RESET
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // write side
   input wire logic wr_i,
   input wire logic [15:0] wdata_i,
   // contents and decode
   output logic [15:0] value_o,
   output msq_pkg::msq_step_s step_o
);
   logic [15:0] val_q;
   logic [15:0] val_d;

   always_comb begin
      val_d = val_q;
      if (wr_i) begin
         val_d = wdata_i & msq_pkg::WRITABLE_MASK;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         val_q <= RESET_VAL & msq_pkg::WRITABLE_MASK;
      end else begin
         val_q <= val_d;
      end
   end

   assign value_o = val_q;

   always_comb begin
      step_o.active = val_q[msq_pkg::ACTIVE_BIT];
      step_o.pos_sel = val_q[msq_pkg::POS_HI:msq_pkg::POS_LO];
      step_o.pos_internal = val_q[msq_pkg::POS_HI];
      case (val_q[msq_pkg::GAIN_HI:msq_pkg::GAIN_LO])
         2'h0: step_o.gain = msq_pkg::MSQ_GAIN_ONE;
         2'h1: step_o.gain = msq_pkg::MSQ_GAIN_TWO;
         default: step_o.gain = msq_pkg::MSQ_GAIN_FOUR;
      endcase
      if (val_q[msq_pkg::POS_HI:msq_pkg::POS_LO] >= msq_pkg::POS_INTERNAL_FIRST) begin
         step_o.neg_src = msq_pkg::MSQ_NEG_AUTO;
      end else if (val_q[msq_pkg::NEG_BIT]) begin
         step_o.neg_src = msq_pkg::MSQ_NEG_EXT_SEVEN;
      end else begin
         step_o.neg_src = msq_pkg::MSQ_NEG_GROUND;
      end
   end
endmodule
`default_nettype wire

// File: hdl/msq_step_bank.sv
// Purpose: register bank holding the step eight and step nine setup registers
// Assumes: plain strobe port, read data one cycle after the read strobe
// Notes: unmapped reads return zero, unmapped writes are dropped
//
// Summary of operation
// - bit 15 of the step eight register enables step eight, cleared after reset.
// - bits 14:13 pick gain one for 00, two for 01 and four for 10 or 11, reset 00.
// - bits 12:5 are reserved, always read zero and ignore writes.
// - bit 4 picks analog ground when zero and external input seven when one, reset zero.
// - bits 3:0 pick external inputs 0-7 or internal sources from 8 upward, reset 8.
// - internal positive codes 8-15 force automatic negative input, ignoring bit 4.
// - the step nine register sits at 99h and resets to 0009h.
// - the step eight register sits at 98h and resets to 0008h.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module msq_step_bank (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // step eight decode to the sequencer
   input wire logic step_eight_visit_i,
   output logic step_eight_active_o,
   output logic [1:0] step_eight_gain_sel_o,
   output logic step_eight_neg_input_sel_o,
   output logic [3:0] step_eight_pos_input_sel_o,
   output logic step_eight_neg_auto_o,
   // step nine decode
   output msq_pkg::msq_step_s step_nine_o
);
   logic [15:0] s8_val;
   logic [15:0] s9_val;
   msq_pkg::msq_step_s s8_dec;
   msq_pkg::msq_step_s s8_live_q;
   msq_pkg::msq_step_s s8_live_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic wr8;
   logic wr9;

   assign wr8 = wr_i && (addr_i == msq_pkg::STEP8_OFFSET);
   assign wr9 = wr_i && (addr_i == msq_pkg::STEP9_OFFSET);

   // the latched copy resets to fixed decodes; refuse a package reset they would not match
   if (msq_pkg::STEP8_RESET[msq_pkg::GAIN_HI:msq_pkg::GAIN_LO] != 2'h0 ||
       msq_pkg::STEP8_RESET[msq_pkg::POS_HI] != 1'b1) begin : g_bad_step8_reset
      $error("step eight reset value does not match the latched copy");
   end

   if (msq_pkg::STEP8_OFFSET == msq_pkg::STEP9_OFFSET) begin : g_bad_offsets
      $error("step eight and step nine setup registers share one address");
   end

   if ((msq_pkg::STEP8_RESET & ~msq_pkg::WRITABLE_MASK) != 16'h0000 ||
       (msq_pkg::STEP9_RESET & ~msq_pkg::WRITABLE_MASK) != 16'h0000) begin : g_bad_reserved
      $error("a reset value sets reserved bits");
   end

   // reserved bits masked inside the register
   msq_step_reg #(.RESET_VAL(msq_pkg::STEP8_RESET)) u_step8 (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_i(wr8),
      .wdata_i(wdata_i),
      .value_o(s8_val),
      .step_o(s8_dec)
   );

   msq_step_reg #(.RESET_VAL(msq_pkg::STEP9_RESET)) u_step9 (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_i(wr9),
      .wdata_i(wdata_i),
      .value_o(s9_val),
      .step_o(step_nine_o)
   );

   // readback, one cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            msq_pkg::STEP8_OFFSET: rdata_d = s8_val;
            msq_pkg::STEP9_OFFSET: rdata_d = s9_val;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // settings latched when the sequencer enters step eight
   always_comb begin
      s8_live_d = s8_live_q;
      if (step_eight_visit_i) begin
         s8_live_d = s8_dec;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 16'h0000;
         s8_live_q <= '{active: msq_pkg::STEP8_RESET[msq_pkg::ACTIVE_BIT],
                        gain: msq_pkg::MSQ_GAIN_ONE,
                        neg_src: msq_pkg::MSQ_NEG_AUTO,
                        pos_sel: msq_pkg::STEP8_RESET[msq_pkg::POS_HI:msq_pkg::POS_LO],
                        pos_internal: msq_pkg::STEP8_RESET[msq_pkg::POS_HI]};
      end else begin
         rdata_q <= rdata_d;
         s8_live_q <= s8_live_d;
      end
   end

   assign rdata_o = rdata_q;
   assign step_eight_active_o = s8_live_q.active;
   assign step_eight_gain_sel_o = s8_live_q.gain;
   assign step_eight_pos_input_sel_o = s8_live_q.pos_sel;
   // forced low while an internal source is picked
   assign step_eight_neg_input_sel_o = (s8_live_q.neg_src == msq_pkg::MSQ_NEG_EXT_SEVEN);
   assign step_eight_neg_auto_o = (s8_live_q.neg_src == msq_pkg::MSQ_NEG_AUTO);

   sequence s_write8;
      wr_i && addr_i == msq_pkg::STEP8_OFFSET;
   endsequence

   sequence s_read8;
      rd_i && addr_i == msq_pkg::STEP8_OFFSET;
   endsequence

   sequence s_write9;
      wr_i && addr_i == msq_pkg::STEP9_OFFSET;
   endsequence

   sequence s_read9;
      rd_i && addr_i == msq_pkg::STEP9_OFFSET;
   endsequence

   // write, then a read of the same register on the very next cycle
   sequence s_write_read8;
      s_write8 ##1 (s_read8 and !wr_i);
   endsequence

   sequence s_write_read9;
      s_write9 ##1 (s_read9 and !wr_i);
   endsequence

   a_reserved_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_i |=> rdata_o[12:5] == 8'h00)
      else $error("reserved bits read nonzero");

   a_reserved_stored: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s8_val[12:5] == 8'h00 && s9_val[12:5] == 8'h00)
      else $error("reserved bits stored nonzero");

   a_step8_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_write_read8 |=> rdata_o == ($past(wdata_i, 2) & msq_pkg::WRITABLE_MASK))
      else $error("step eight readback mismatch");

   a_step9_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_write_read9 |=> rdata_o == ($past(wdata_i, 2) & msq_pkg::WRITABLE_MASK))
      else $error("step nine readback mismatch");

   a_idle_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == 16'h0000)
      else $error("read data outside its cycle");

   a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_i && addr_i != msq_pkg::STEP8_OFFSET && addr_i != msq_pkg::STEP9_OFFSET
      |=> rdata_o == 16'h0000)
      else $error("unmapped read nonzero");

   a_write_dropped: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_i && addr_i != msq_pkg::STEP8_OFFSET && addr_i != msq_pkg::STEP9_OFFSET
      |=> $stable(s8_val) && $stable(s9_val))
      else $error("unmapped write changed a register");

   a_reset_values: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> s8_val == msq_pkg::STEP8_RESET && s9_val == msq_pkg::STEP9_RESET)
      else $error("register reset value wrong");

   a_latched_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !step_eight_active_o && step_eight_neg_auto_o &&
         step_eight_pos_input_sel_o == msq_pkg::STEP8_RESET[msq_pkg::POS_HI:msq_pkg::POS_LO])
      else $error("latched step eight reset wrong");

   a_enable_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_eight_visit_i |=> step_eight_active_o == $past(s8_val[15]))
      else $error("step enable not taken");

   a_gain_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_eight_visit_i |=> step_eight_gain_sel_o ==
         ($past(s8_val[14:13]) == 2'h3 ? 2'h2 : $past(s8_val[14:13])))
      else $error("gain decode wrong");

   a_neg_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_eight_visit_i && !s8_val[3] |=> step_eight_neg_input_sel_o == $past(s8_val[4]))
      else $error("negative select wrong");

   a_pos_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_eight_visit_i |=> step_eight_pos_input_sel_o == $past(s8_val[3:0]))
      else $error("positive select wrong");

   a_neg_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_eight_pos_input_sel_o[3] |-> step_eight_neg_auto_o && !step_eight_neg_input_sel_o)
      else $error("internal source without auto negative");

   a_external_no_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !step_eight_pos_input_sel_o[3] |-> !step_eight_neg_auto_o)
      else $error("external source with auto negative");

   a_latch_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !step_eight_visit_i |=> $stable(step_eight_active_o) && $stable(step_eight_gain_sel_o) &&
         $stable(step_eight_neg_input_sel_o) && $stable(step_eight_pos_input_sel_o))
      else $error("step eight settings changed without a visit");

   a_nine_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      step_nine_o.pos_sel >= msq_pkg::POS_INTERNAL_FIRST |->
         step_nine_o.neg_src == msq_pkg::MSQ_NEG_AUTO && step_nine_o.pos_internal)
      else $error("step nine internal source without auto negative");

   a_nine_neg_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !step_nine_o.pos_internal |-> step_nine_o.neg_src ==
         (s9_val[msq_pkg::NEG_BIT] ? msq_pkg::MSQ_NEG_EXT_SEVEN : msq_pkg::MSQ_NEG_GROUND))
      else $error("step nine negative select wrong");
endmodule
`default_nettype wire

// File: dv/test_msq_step_bank.sv
// Purpose: self-checking bench for the step setup register bank
// Assumes: plain strobe register port, read data one cycle after the strobe
// Notes: latched step eight outputs are checked after each visit pulse
`timescale 1ns/10ps
`default_nettype none
module test_msq_step_bank;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic visit_i = 1'b0;
   logic [15:0] rdata_o;
   logic act_o, neg_o, auto_o;
   logic [1:0] gain_o;
   logic [3:0] pos_o;
   msq_pkg::msq_step_s nine_o;
   logic [15:0] v;
   int mismatches = 0;
   int n_tests = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   msq_step_bank uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .step_eight_visit_i(visit_i),
      .step_eight_active_o(act_o), .step_eight_gain_sel_o(gain_o),
      .step_eight_neg_input_sel_o(neg_o), .step_eight_pos_input_sel_o(pos_o),
      .step_eight_neg_auto_o(auto_o), .step_nine_o(nine_o)
   );

   // expected latched outputs: active, gain, neg, pos, auto
   function automatic logic [8:0] exp_step(input logic [15:0] r);
      return {r[15], (r[14] ? 2'h2 : {1'b0, r[13]}), r[4] & ~r[3], r[3:0], r[3]};
   endfunction

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_step(input logic [15:0] r);
      n_tests++;
      if ({act_o, gain_o, neg_o, pos_o, auto_o} !== exp_step(r)) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time,
            {act_o, gain_o, neg_o, pos_o, auto_o}, exp_step(r));
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk_reg(rdata_o, exp);
   endtask

   // write, then read back on the next cycle with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk_reg(rdata_o, exp);
   endtask

   task automatic visit(input logic [15:0] r);
      @(posedge sys_clk_i);
      visit_i <= 1'b1;
      @(posedge sys_clk_i);
      visit_i <= 1'b0;
      #1 chk_step(r);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(8'h98, 16'h0008);
      rd(8'h99, 16'h0009);
      rd(8'h97, 16'h0000);
      chk_step(16'h0008);
      $display("test reset values done");
      wr(8'h98, 16'hffff);
      rd(8'h98, 16'he01f);
      chk_step(16'h0008);
      visit(16'he01f);
      wr(8'h9a, 16'h0000);
      rd(8'h98, 16'he01f);
      rd(8'h9a, 16'h0000);
      wr_rd(8'h98, 16'h7fe5, 16'h6005);
      $display("test reserved and readback done");
      for (int g = 0; g < 4; g++) begin
         v = {1'b1, 2'(g), 8'h00, 1'b1, 4'h3};
         wr(8'h98, v);
         visit(v);
      end
      $display("test gain codes done");
      for (int p = 0; p < 16; p++) begin
         v = {1'b0, 2'b01, 8'h00, 1'b1, 4'(p)};
         wr(8'h98, v);
         rd(8'h98, v);
         visit(v);
      end
      $display("test input codes done");
      wr_rd(8'h99, 16'h2a7e, 16'h201e);
      wr(8'h99, 16'hdff1);
      rd(8'h99, 16'hc011);
      chk_reg({6'h00, nine_o}, {6'h00, msq_pkg::msq_step_s'{1'b1, msq_pkg::MSQ_GAIN_FOUR,
         msq_pkg::MSQ_NEG_EXT_SEVEN, 4'h1, 1'b0}});
      wr(8'h99, 16'h001c);
      #1 chk_reg({6'h00, nine_o}, {6'h00, msq_pkg::msq_step_s'{1'b0, msq_pkg::MSQ_GAIN_ONE,
         msq_pkg::MSQ_NEG_AUTO, 4'hc, 1'b1}});
      rd(8'h98, v);
      $display("test step nine done");
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(8'h98, 16'h0008);
      rd(8'h99, 16'h0009);
      chk_step(16'h0008);
      $display("test reset in mid-run done");
      test_done();
   end
endmodule
`default_nettype wire
